/* rtl/acevs_map.svh */
// Offsets, field positions, reset values and encodings of the control/event bank.
// Assumes byte offsets within the configuration space and dword-wide accesses.
`ifndef ACEVS_MAP_SVH
`define ACEVS_MAP_SVH

`define ACEVS_GCTL_OFS    8'h86
`define ACEVS_EVST_OFS    8'h88
`define ACEVS_GCTL_DW     6'h21
`define ACEVS_EVST_DW     6'h22
`define ACEVS_GCTL_LANE   2
`define ACEVS_EVST_LANE   0

`define ACEVS_GCTL_RST    16'h0000
`define ACEVS_GCTL_WMASK  16'hfcbb
`define ACEVS_EVST_RST    8'h00
`define ACEVS_EVST_MASK   8'hdf

`define ACEVS_EV_PWR      7
`define ACEVS_EV_VPP      6
`define ACEVS_GPI_N       5

`define ACEVS_VPP_12V     2'h2
`define ACEVS_ARB_1394    2'h0
`define ACEVS_ARB_CB      2'h1

`endif

/* rtl/acevs_pkg.sv */
// Types shared by the control/event bank and its users.
// Assumes acevs_map.svh supplies offsets and masks; field widths and arbitration encodings are set here.
package acevs_pkg;

   typedef struct packed {
      logic [2:0] test_bits;
      logic       io_limit_force;
      logic       io_base_force;
      logic       power_switch_type_select;
      logic [1:0] rsvd_9_8;
      logic       bus_rev23_conformance;
      logic       rsvd_6;
      logic       loader_function_off;
      logic       dedicated_socket_off;
      logic       host_1394_function_off;
      logic       rsvd_2;
      logic [1:0] top_arbitration_policy;
   } acevs_gctl_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [5:0]  dw;
      logic [3:0]  be;
      logic [31:0] wdata;
   } acevs_cfg_req_t;

   typedef struct packed {
      logic [1:0] vcc;
      logic [1:0] vpp;
   } acevs_pwr_t;

   typedef enum logic [1:0] {
      ACEVS_ARB_PRI_1394 = 2'b00,
      ACEVS_ARB_PRI_CB   = 2'b01,
      ACEVS_ARB_RR_A     = 2'b10,
      ACEVS_ARB_RR_B     = 2'b11
   } acevs_arb_t;

endpackage

/* rtl/acevs_regs.sv */
// General control and event status registers of the card/serial bus controller.
// Assumes a dword configuration access port on mclk; pins arrive asynchronously.
// Overview of operation
// (R1) Software keeps the three top test bits at their zero reset pattern.
// (R2) I/O limit force bit drives bit 0 of both functions' I/O limit.
// (R3) I/O base force bit drives bit 0 of both functions' I/O base.
// (R4) Switch type bit: 0 means 1.8 V switch, 1 means 12 V switch.
// (R5) Control bits 9:8, 6 and 2 always read zero.
// (R6) Revision bit set selects 2.3 behaviour, clear selects 2.2.
// (R7) Loader-off bit makes the firmware loader inaccessible.
// (R8) Dedicated-socket-off bit makes that socket function inaccessible.
// (R9) Controller-off bit makes the 1394 host function inaccessible.
// (R10) Arbitration field: 00 serial first, 01 card first, 1x round robin.
// (R11) Only the global reset clears both registers; control resets to zero.
// (R12) Any socket supply or programming voltage change sets the power flag.
// (R13) Programming voltage moving into or out of 12 V sets its flag.
// (R14) Input flags set on pin level change while pin is a general input.
// (R15) Event status bit 5 reads zero, writes ignored.
// (R16) Event flags may drive the event output line.
// (R17) Event flags hardware-set, software-cleared, reset to zero.
// (R18) Output asserted per flag only while its enable bit is set.
// (R19) Writing 1 clears a flag; a simultaneous hardware set wins.
`include "acevs_map.svh"

module acevs_regs (
   input  wire logic                          mclk,
   input  wire logic                          rst,
   input  wire logic                          bus_reset,
   input  wire acevs_pkg::acevs_cfg_req_t     cfg_req,
   output logic      [31:0]                   cfg_rdata,
   output logic                               cfg_ack,
   input  wire acevs_pkg::acevs_pwr_t [1:0]   socket_power,
   input  wire logic [`ACEVS_GPI_N-1:0]       multipurpose_pin,
   input  wire logic [`ACEVS_GPI_N-1:0]       pin_is_gen_input,
   input  wire logic [7:0]                    event_enable,
   output logic                               event_output_line_n,
   output logic                               io_limit_bit0,
   output logic                               io_base_bit0,
   output logic                               power_switch_type_select,
   output logic                               bus_rev23_conformance,
   output logic                               loader_function_off,
   output logic                               dedicated_socket_off,
   output logic                               host_1394_function_off,
   output acevs_pkg::acevs_arb_t              top_arbitration_policy
);
   import acevs_pkg::*;

   acevs_gctl_t                gctl_reg;
   logic [7:0]                 evst_reg;
   logic [7:0]                 evst_next;
   logic [7:0]                 ev_set;
   logic [7:0]                 ev_clr;
   acevs_pwr_t [1:0]           pwr_prev_reg;
   logic                       pwr_seen_reg;
   logic [`ACEVS_GPI_N-1:0]    gpi_meta_reg;
   logic [`ACEVS_GPI_N-1:0]    gpi_sync_reg;
   logic [`ACEVS_GPI_N-1:0]    gpi_prev_reg;
   logic [`ACEVS_GPI_N-1:0]    gpi_edge;
   logic                       pwr_change;
   logic                       vpp12_change;
   logic                       gctl_hit;
   logic                       evst_hit;
   logic [31:0]                rdata_reg;
   logic                       ack_reg;
   logic                       event_n_reg;
   logic [15:0]                gctl_wdata;

   // Register decode
   assign gctl_hit = (cfg_req.dw == `ACEVS_GCTL_DW);
   assign evst_hit = (cfg_req.dw == `ACEVS_EVST_DW);

   // Control write: test bits kept as written, software holds them at zero (R1)
   assign gctl_wdata = cfg_req.wdata[31:16] & `ACEVS_GCTL_WMASK; // R5

   always_ff @(posedge mclk) begin
      if (rst) begin
         gctl_reg <= `ACEVS_GCTL_RST; // R11
      end else if (cfg_req.wr && gctl_hit) begin
         if (cfg_req.be[`ACEVS_GCTL_LANE]) begin
            gctl_reg[7:0] <= gctl_wdata[7:0];
         end
         if (cfg_req.be[`ACEVS_GCTL_LANE+1]) begin
            gctl_reg[15:8] <= gctl_wdata[15:8];
         end
      end
   end

   // Field outputs straight from the control flops
   assign io_limit_bit0            = gctl_reg.io_limit_force; // R2
   assign io_base_bit0             = gctl_reg.io_base_force; // R3
   assign power_switch_type_select = gctl_reg.power_switch_type_select; // R4
   assign bus_rev23_conformance    = gctl_reg.bus_rev23_conformance; // R6
   assign loader_function_off      = gctl_reg.loader_function_off; // R7
   assign dedicated_socket_off     = gctl_reg.dedicated_socket_off; // R8
   assign host_1394_function_off   = gctl_reg.host_1394_function_off; // R9
   assign top_arbitration_policy   = acevs_arb_t'(gctl_reg.top_arbitration_policy); // R10

   // Socket power history; first sample after reset only primes it
   always_ff @(posedge mclk) begin
      if (rst) begin
         pwr_prev_reg <= '0;
         pwr_seen_reg <= 1'b0;
      end else begin
         pwr_prev_reg <= socket_power;
         pwr_seen_reg <= 1'b1;
      end
   end

   always_comb begin
      pwr_change   = 1'b0;
      vpp12_change = 1'b0;
      for (int s = 0; s < 2; s++) begin
         if (socket_power[s] != pwr_prev_reg[s]) begin
            pwr_change = pwr_seen_reg; // R12
         end
         if ((socket_power[s].vpp == `ACEVS_VPP_12V) != (pwr_prev_reg[s].vpp == `ACEVS_VPP_12V)) begin
            vpp12_change = pwr_seen_reg; // R13
         end
      end
   end

   // Pin synchronisers; the edge detector compares the second and third stages
   genvar g;
   generate
      for (g = 0; g < `ACEVS_GPI_N; g++) begin : g_gpi
         always_ff @(posedge mclk) begin
            if (rst) begin
               gpi_meta_reg[g] <= 1'b0;
               gpi_sync_reg[g] <= 1'b0;
               gpi_prev_reg[g] <= 1'b0;
            end else begin
               gpi_meta_reg[g] <= multipurpose_pin[g];
               gpi_sync_reg[g] <= gpi_meta_reg[g];
               gpi_prev_reg[g] <= gpi_sync_reg[g];
            end
         end
         assign gpi_edge[g] = (gpi_sync_reg[g] ^ gpi_prev_reg[g]) & pin_is_gen_input[g]; // R14
      end
   endgenerate

   // Event flags: set beats clear, bit 5 never stored
   assign ev_set = {pwr_change, vpp12_change, 1'b0, gpi_edge};
   assign ev_clr = (cfg_req.wr && evst_hit && cfg_req.be[`ACEVS_EVST_LANE])
                   ? cfg_req.wdata[7:0] : 8'h00;
   assign evst_next = ((evst_reg & ~ev_clr) | ev_set) & `ACEVS_EVST_MASK; // R15 R19

   always_ff @(posedge mclk) begin
      if (rst) begin
         evst_reg <= `ACEVS_EVST_RST; // R11 R17
      end else begin
         evst_reg <= evst_next; // R17
      end
   end

   // Active-low event line, gated per flag by its enable
   always_ff @(posedge mclk) begin
      if (rst) begin
         event_n_reg <= 1'b1;
      end else begin
         event_n_reg <= ~|(evst_reg & event_enable); // R16 R18
      end
   end
   assign event_output_line_n = event_n_reg;

   // Read path; bus reset drops only the answer, never the registers
   always_ff @(posedge mclk) begin
      if (rst || bus_reset) begin
         rdata_reg <= 32'h0000_0000;
         ack_reg   <= 1'b0;
      end else begin
         ack_reg <= cfg_req.rd | cfg_req.wr;
         if (cfg_req.rd) begin
            if (gctl_hit) begin
               rdata_reg <= {gctl_reg & `ACEVS_GCTL_WMASK, 16'h0000}; // R5
            end else if (evst_hit) begin
               rdata_reg <= {24'h00_0000, evst_reg}; // R15
            end else begin
               rdata_reg <= 32'h0000_0000;
            end
         end
      end
   end
   assign cfg_rdata = rdata_reg;
   assign cfg_ack   = ack_reg;

   // Helper state for the checks below
   logic        rd_gctl_q;
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_gctl_q <= 1'b0;
      end else begin
         rd_gctl_q <= cfg_req.rd & gctl_hit;
      end
   end

   a_reset_clears: assert property (@(posedge mclk) // R11
      $past(rst) |-> (gctl_reg == `ACEVS_GCTL_RST) && (evst_reg == `ACEVS_EVST_RST))
      else $error("registers not cleared by global reset");

   a_limit_write: assert property (@(posedge mclk) disable iff (rst) // R2
      (cfg_req.wr && gctl_hit && cfg_req.be[`ACEVS_GCTL_LANE+1]) |=> io_limit_bit0 == $past(cfg_req.wdata[28]))
      else $error("io limit bit does not follow write");

   a_base_write: assert property (@(posedge mclk) disable iff (rst) // R3
      (cfg_req.wr && gctl_hit && cfg_req.be[`ACEVS_GCTL_LANE+1]) |=> io_base_bit0 == $past(cfg_req.wdata[27]))
      else $error("io base bit does not follow write");

   a_arb_write: assert property (@(posedge mclk) disable iff (rst) // R10
      (cfg_req.wr && gctl_hit && cfg_req.be[`ACEVS_GCTL_LANE]) |=>
      top_arbitration_policy == $past(cfg_req.wdata[17:16]))
      else $error("arbitration field does not follow write");

   a_rsvd_read: assert property (@(posedge mclk) disable iff (rst || bus_reset) // R5
      rd_gctl_q |-> (cfg_rdata[25:24] == 2'b00) && !cfg_rdata[22] && !cfg_rdata[18])
      else $error("reserved control bits read nonzero");

   a_bit5_zero: assert property (@(posedge mclk) disable iff (rst) // R15
      !evst_reg[5])
      else $error("event status bit 5 set");

   a_pwr_flag: assert property (@(posedge mclk) disable iff (rst) // R12
      (pwr_seen_reg && socket_power != pwr_prev_reg) |=> evst_reg[`ACEVS_EV_PWR])
      else $error("power change flag not set");

   a_vpp_flag: assert property (@(posedge mclk) disable iff (rst) // R13
      vpp12_change |=> evst_reg[`ACEVS_EV_VPP] ##1 $stable(evst_reg[`ACEVS_EV_VPP]) || $past(ev_clr[`ACEVS_EV_VPP]))
      else $error("12 V request flag not held");

   a_gpi_flag: assert property (@(posedge mclk) disable iff (rst) // R14
      (pin_is_gen_input[0] && $changed(gpi_sync_reg[0])) |=> evst_reg[0])
      else $error("input change flag not set");

   a_gpi_masked: assert property (@(posedge mclk) disable iff (rst) // R14
      (!evst_reg[0] && !pin_is_gen_input[0]) |=> !evst_reg[0])
      else $error("input flag set while pin not a general input");

   a_w1c_clear: assert property (@(posedge mclk) disable iff (rst) // R19
      (ev_clr[0] && !ev_set[0]) |=> !evst_reg[0])
      else $error("write one did not clear flag");

   a_set_wins: assert property (@(posedge mclk) disable iff (rst) // R19
      (ev_clr[`ACEVS_EV_PWR] && pwr_change) |=> evst_reg[`ACEVS_EV_PWR])
      else $error("clear beat a simultaneous set");

   a_event_gated: assert property (@(posedge mclk) disable iff (rst) // R18
      (evst_reg & event_enable) == 8'h00 [*2] |-> event_output_line_n)
      else $error("event line asserted without enabled flag");

   a_event_drive: assert property (@(posedge mclk) disable iff (rst) // R16
      ((evst_reg & event_enable) != 8'h00) |=> !event_output_line_n)
      else $error("event line not asserted for enabled flag");

   // Field checks: each control output must follow its own data bit
   a_switch_write: assert property (@(posedge mclk) disable iff (rst) // R4
      (cfg_req.wr && gctl_hit && cfg_req.be[`ACEVS_GCTL_LANE+1]) |=> power_switch_type_select == $past(cfg_req.wdata[26]))
      else $error("switch type bit does not follow write");

   a_rev_write: assert property (@(posedge mclk) disable iff (rst) // R6
      (cfg_req.wr && gctl_hit && cfg_req.be[`ACEVS_GCTL_LANE]) |=> bus_rev23_conformance == $past(cfg_req.wdata[23]))
      else $error("revision bit does not follow write");

   a_loader_write: assert property (@(posedge mclk) disable iff (rst) // R7
      (cfg_req.wr && gctl_hit && cfg_req.be[`ACEVS_GCTL_LANE]) |=> loader_function_off == $past(cfg_req.wdata[21]))
      else $error("loader off bit does not follow write");

   a_socket_write: assert property (@(posedge mclk) disable iff (rst) // R8
      (cfg_req.wr && gctl_hit && cfg_req.be[`ACEVS_GCTL_LANE]) |=> dedicated_socket_off == $past(cfg_req.wdata[20]))
      else $error("socket off bit does not follow write");

   a_host_off_write: assert property (@(posedge mclk) disable iff (rst) // R9
      (cfg_req.wr && gctl_hit && cfg_req.be[`ACEVS_GCTL_LANE]) |=> host_1394_function_off == $past(cfg_req.wdata[19]))
      else $error("controller off bit does not follow write");

   // Bus reset must leave the control word alone; only a write moves it
   a_ctl_hold: assert property (@(posedge mclk) disable iff (rst) // R11
      !(cfg_req.wr && gctl_hit) |=> $stable(gctl_reg))
      else $error("control register changed without a write");

   a_rsvd_store: assert property (@(posedge mclk) disable iff (rst) // R5
      (gctl_reg[9:8] == 2'b00) && !gctl_reg[6] && !gctl_reg[2])
      else $error("reserved control bits stored nonzero");

   a_ctl_read: assert property (@(posedge mclk) disable iff (rst || bus_reset) // R5
      (cfg_req.rd && gctl_hit) |=> (cfg_rdata[15:0] == 16'h0000) && (cfg_rdata[31:16] == $past(gctl_reg)))
      else $error("control read data wrong");

   a_evst_read: assert property (@(posedge mclk) disable iff (rst || bus_reset) // R17
      (cfg_req.rd && evst_hit) |=> cfg_rdata == {24'h00_0000, $past(evst_reg)})
      else $error("status read data wrong");

   a_bit5_read: assert property (@(posedge mclk) disable iff (rst || bus_reset) // R15
      (cfg_req.rd && evst_hit) |=> !cfg_rdata[5])
      else $error("status bit 5 read nonzero");

   // Flags are sticky: only a write of one may drop them
   a_pwr_sticky: assert property (@(posedge mclk) disable iff (rst) // R17
      (evst_reg[`ACEVS_EV_PWR] && !ev_clr[`ACEVS_EV_PWR]) |=> evst_reg[`ACEVS_EV_PWR])
      else $error("power flag dropped without clear");

   a_vpp_sticky: assert property (@(posedge mclk) disable iff (rst) // R17
      (evst_reg[`ACEVS_EV_VPP] && !ev_clr[`ACEVS_EV_VPP]) |=> evst_reg[`ACEVS_EV_VPP])
      else $error("12 V flag dropped without clear");

   a_pwr_hw_only: assert property (@(posedge mclk) disable iff (rst) // R17
      (!evst_reg[`ACEVS_EV_PWR] && !pwr_change) |=> !evst_reg[`ACEVS_EV_PWR])
      else $error("power flag set without a change");

   a_vpp_masked: assert property (@(posedge mclk) disable iff (rst) // R13
      (!evst_reg[`ACEVS_EV_VPP] && !vpp12_change) |=> !evst_reg[`ACEVS_EV_VPP])
      else $error("12 V flag set without a 12 V move");

   a_w1c_power: assert property (@(posedge mclk) disable iff (rst) // R19
      (ev_clr[`ACEVS_EV_PWR] && !ev_set[`ACEVS_EV_PWR]) |=> !evst_reg[`ACEVS_EV_PWR])
      else $error("write one did not clear power flag");

   a_w0_keeps: assert property (@(posedge mclk) disable iff (rst) // R19
      (evst_reg[0] && cfg_req.wr && evst_hit && !cfg_req.wdata[0]) |=> evst_reg[0])
      else $error("write zero cleared a flag");

   // Upper pins checked too, so a lane swap in the flag vector shows up
   a_gpi1_flag: assert property (@(posedge mclk) disable iff (rst) // R14
      (pin_is_gen_input[1] && $changed(gpi_sync_reg[1])) |=> evst_reg[1])
      else $error("input 1 change flag not set");

   a_gpi2_flag: assert property (@(posedge mclk) disable iff (rst) // R14
      (pin_is_gen_input[2] && $changed(gpi_sync_reg[2])) |=> evst_reg[2])
      else $error("input 2 change flag not set");

   a_gpi3_flag: assert property (@(posedge mclk) disable iff (rst) // R14
      (pin_is_gen_input[3] && $changed(gpi_sync_reg[3])) |=> evst_reg[3])
      else $error("input 3 change flag not set");

   a_gpi4_flag: assert property (@(posedge mclk) disable iff (rst) // R14
      (pin_is_gen_input[4] && $changed(gpi_sync_reg[4])) |=> evst_reg[4])
      else $error("input 4 change flag not set");

   a_gpi4_masked: assert property (@(posedge mclk) disable iff (rst) // R14
      (!evst_reg[4] && !pin_is_gen_input[4]) |=> !evst_reg[4])
      else $error("input 4 flag set while pin not a general input");

endmodule // acevs_regs

/* testbench/acevs_host_model.sv */
// Host model: configuration software issuing dword accesses to the bank.
// Assumes the bank answers every request with a one-cycle cfg_ack.
`include "acevs_map.svh"

module acevs_host_model (
   input  wire logic                      mclk,
   output acevs_pkg::acevs_cfg_req_t      cfg_req,
   input  wire logic [31:0]               cfg_rdata,
   input  wire logic                      cfg_ack
);
   timeunit 1ns;
   timeprecision 100ps;
   import acevs_pkg::*;

   initial cfg_req = '0;

   // One-cycle pulse per the port contract, then a bounded wait for the ack
   task automatic xfer(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] rdat, output logic ok);
      int n;
      n = 0;
      @(posedge mclk);
      #1;
      if (wr && dw == `ACEVS_GCTL_DW) wd[31:29] = 3'h0;
      cfg_req = '{rd: !wr, wr: wr, dw: dw, be: be, wdata: wd};
      @(posedge mclk);
      #1;
      // Released lines carry junk so stale values cannot pass for real ones
      cfg_req = '{rd: 1'b0, wr: 1'b0, dw: ~dw, be: ~be, wdata: ~wd};
      while (cfg_ack !== 1'b1 && n < 4) begin
         @(posedge mclk);
         #1;
         n++;
      end
      ok = (cfg_ack === 1'b1);
      rdat = cfg_rdata;
   endtask
endmodule // acevs_host_model

/* testbench/arb_control_event_status_tb_top.sv */
// Self-checking bench for the control/event register bank.
// Assumes acevs_regs and acevs_host_model; pins and power driven here.
`include "acevs_map.svh"

module arb_control_event_status_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import acevs_pkg::*;

   logic                 mclk, rst, bus_reset, cfg_ack, ok;
   acevs_cfg_req_t       cfg_req;
   logic [31:0]          cfg_rdata, rdat;
   acevs_pwr_t [1:0]     socket_power;
   logic [4:0]           multipurpose_pin, pin_is_gen_input;
   logic [7:0]           event_enable;
   logic                 event_output_line_n, io_limit_bit0, io_base_bit0, power_switch_type_select;
   logic                 bus_rev23_conformance, loader_function_off, dedicated_socket_off, host_1394_function_off;
   acevs_arb_t           top_arbitration_policy;
   int                   err_total, cmp_count, cyc;

   acevs_regs dut (.mclk(mclk), .rst(rst), .bus_reset(bus_reset), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
      .cfg_ack(cfg_ack), .socket_power(socket_power), .multipurpose_pin(multipurpose_pin),
      .pin_is_gen_input(pin_is_gen_input), .event_enable(event_enable), .event_output_line_n(event_output_line_n),
      .io_limit_bit0(io_limit_bit0), .io_base_bit0(io_base_bit0), .power_switch_type_select(power_switch_type_select),
      .bus_rev23_conformance(bus_rev23_conformance), .loader_function_off(loader_function_off),
      .dedicated_socket_off(dedicated_socket_off), .host_1394_function_off(host_1394_function_off),
      .top_arbitration_policy(top_arbitration_policy));
   acevs_host_model u_host (.mclk(mclk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));

   always #5 mclk = ~mclk;

   task automatic print_verdict;
      $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Hang guard: whole run needs well under a thousand cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         $display("mismatch cycle limit expected %0d seen %0d", 2999, cyc);
         print_verdict();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr_ctl(input logic [15:0] v);
      u_host.xfer(1'b1, `ACEVS_GCTL_DW, 4'hc, {v, 16'h0000}, rdat, ok);
      chk("ctl write ack", 32'h1, {31'h0, ok});
   endtask
   task automatic rd_ctl(input logic [15:0] exp);
      u_host.xfer(1'b0, `ACEVS_GCTL_DW, 4'hf, 32'h0, rdat, ok);
      chk("ctl read", {16'h0000, exp}, {15'h0, !ok, rdat[31:16]});
   endtask
   task automatic wr_ev(input logic [7:0] m);
      u_host.xfer(1'b1, `ACEVS_EVST_DW, 4'h1, {24'h0, m}, rdat, ok);
      chk("ev write ack", 32'h1, {31'h0, ok});
   endtask
   task automatic rd_ev(input logic [7:0] exp);
      u_host.xfer(1'b0, `ACEVS_EVST_DW, 4'hf, 32'h0, rdat, ok);
      chk("ev read", {24'h0, exp}, {23'h0, !ok, rdat[7:0]});
   endtask
   function automatic logic [31:0] fields();
      return {23'h0, io_limit_bit0, io_base_bit0, power_switch_type_select, bus_rev23_conformance,
              loader_function_off, dedicated_socket_off, host_1394_function_off, top_arbitration_policy};
   endfunction

   task automatic t_reset;
      rd_ctl(16'h0000);
      rd_ev(8'h00);
      chk("fields", 32'h0, fields());
      chk("event line", 32'h1, {31'h0, event_output_line_n});
      $display("t_reset done");
   endtask
   task automatic t_fields;
      wr_ctl(16'hffff);
      rd_ctl(16'h1cbb);
      chk("fields", 32'h1ff, fields());
      for (int i = 0; i < 4; i++) begin
         wr_ctl(16'(i));
         chk("arbitration", i, fields());
      end
      wr_ctl(16'h1400);
      bus_reset = 1'b1;
      cycles(2);
      bus_reset = 1'b0;
      rd_ctl(16'h1400);
      chk("fields", 32'h140, fields());
      $display("t_fields done");
   endtask
   task automatic t_power;
      event_enable = 8'h80;
      socket_power[0].vcc = 2'h1;
      cycles(3);
      rd_ev(8'h80);
      chk("event line", 32'h0, {31'h0, event_output_line_n});
      event_enable = 8'h00;
      cycles(2);
      chk("event line", 32'h1, {31'h0, event_output_line_n});
      wr_ev(8'h80);
      rd_ev(8'h00);
      socket_power[1].vpp = `ACEVS_VPP_12V;
      cycles(3);
      rd_ev(8'hc0);
      wr_ev(8'h40);
      rd_ev(8'h80);
      wr_ev(8'h80);
      socket_power[1].vpp = 2'h1;
      cycles(3);
      rd_ev(8'hc0);
      wr_ev(8'hc0);
      socket_power[1].vpp = 2'h3;
      cycles(3);
      rd_ev(8'h80);
      wr_ev(8'h80);
      $display("t_power done");
   endtask
   task automatic t_pins;
      multipurpose_pin = 5'h1f;
      cycles(5);
      rd_ev(8'h00);
      pin_is_gen_input = 5'h1f;
      multipurpose_pin = 5'h0a;
      cycles(5);
      rd_ev(8'h15);
      multipurpose_pin = 5'h00;
      event_enable = 8'h01;
      cycles(5);
      rd_ev(8'h1f);
      chk("event line", 32'h0, {31'h0, event_output_line_n});
      wr_ev(8'hff);
      rd_ev(8'h00);
      cycles(2);
      chk("event line", 32'h1, {31'h0, event_output_line_n});
      $display("t_pins done");
   endtask

   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      bus_reset = 1'b0;
      socket_power = '0;
      multipurpose_pin = 5'h00;
      pin_is_gen_input = 5'h00;
      event_enable = 8'h00;
      repeat (5) @(posedge mclk);
      #1;
      rst = 1'b0;
      t_reset();
      t_fields();
      t_power();
      t_pins();
      print_verdict();
   end
endmodule // arb_control_event_status_tb_top
